// *** common/hwcc_cfg.svh ***
// Constants for the halt, wake-up and clock control block.
`ifndef HWCC_CFG_SVH
`define HWCC_CFG_SVH
`define HWCC_PORT_W 8
`define HWCC_IRQ_W 4
`define HWCC_RESTART_CYCLES 1024
`define HWCC_CNT_W 11
`define HWCC_DIV_W 2
`define HWCC_DIV_LAST 2'h3
`define HWCC_DIV_HALF 2'h2
`define HWCC_WDT_OSC_PERIOD_NS 65000
`define HWCC_REG_W 12
`define HWCC_ADDR_CTRL 12'h000
`define HWCC_ADDR_STATUS 12'h004
`define HWCC_ADDR_CONFIG 12'h008
`define HWCC_CTRL_HALT 0
`define HWCC_CTRL_CLRWDT 1
`define HWCC_ST_PDF 0
`define HWCC_ST_TO 1
`define HWCC_ST_HALTED 2
`define HWCC_ST_DELAY 3
`define HWCC_CFG_RC 0
`define HWCC_CFG_WDTOSC 1
`define HWCC_CFG_WAKE_LSB 8
`endif

// *** common/hwcc_pkg.sv ***
// Types for the halt, wake-up and clock control block.
package hwcc_pkg;
   typedef enum logic [1:0] {
      hwcc_run = 2'b00,
      hwcc_halted = 2'b01,
      hwcc_restart = 2'b10
   } hwcc_state_type;
   typedef enum logic [1:0] {
      hwcc_cause_none = 2'b00,
      hwcc_cause_port = 2'b01,
      hwcc_cause_irq = 2'b10,
      hwcc_cause_wdt = 2'b11
   } hwcc_cause_type;
   typedef struct packed {
      hwcc_state_type state;
      hwcc_cause_type cause;
      logic [10:0] count;
      logic power_down_flag;
      logic watchdog_timeout_flag;
      logic [7:0] wake_enable;
      logic rc_mode;
      logic wdt_from_osc;
      logic [7:0] port_prev;
      logic [3:0] irq_masked;
      logic osc_run;
      logic core_stall;
      logic resume_next;
      logic irq_service;
      logic wdt_clear;
      logic wdt_run;
      logic wdt_reset;
      logic [1:0] div;
      logic osc_out_pin_oe_n;
      logic [31:0] prdata;
      logic pready;
   } hwcc_state_all_type;
endpackage

// *** rtl/hwcc_top.sv ***
// Halt entry, wake-up, restart delay and system clock output control.
`timescale 1ns/1ps
`include "hwcc_cfg.svh"
// Overview of operation
// - Halt state is entered by the halt instruction strobe or by a CTRL register write with the halt bit set.
// - Halt stops the system oscillator and stalls the core at halt.
// - While halted core stays stalled so memory, registers and ports hold.
// - Halt clears watchdog; it runs only when clocked by its own oscillator.
// - Halt sets the power-down flag and clears the time-out flag.
// - Wake on external reset, enabled port falling edge, interrupt or watchdog overflow.
// - External reset wake resets fully; watchdog overflow wake starts a watchdog reset.
// - Power-down flag clears on power-up or clear-watchdog, sets on halt.
// - Watchdog timeout in halt sets time-out flag, resets only PC and stack.
// - Each port pin has its own fixed wake enable bit.
// - Port wake resumes at the instruction after halt.
// - Disabled interrupt or full stack resumes after halt, request stays pending.
// - Enabled interrupt with stack room gets normal interrupt response.
// - Interrupt flag already set at halt entry cannot wake the device.
// - Every wake except external reset waits 1024 system clocks before resuming.
// - Interrupt service starts immediately after the delay ends, in the same cycle a resume would.
// - Resume at next instruction happens immediately after the delay ends.
// - One system clock source, crystal or RC, chosen by fixed configuration.
// - In RC mode the open-drain output pin carries system clock divided by four.
// - Selected watchdog oscillator keeps running during halt.
// - Watchdog counter cleared by reset pin, clear-watchdog or halt.
module hwcc_top
   import hwcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_instr,
   input wire logic clear_watchdog_instr,
   input wire logic external_reset_pin_n,
   input wire logic [7:0] port_a_in,
   input wire logic [3:0] irq_flag,
   input wire logic [3:0] irq_enable,
   input wire logic stack_full,
   input wire logic wdt_overflow,
   output logic osc_run,
   output logic core_stall,
   output logic resume_next,
   output logic irq_service,
   output logic wdt_clear,
   output logic wdt_run,
   output logic wdt_reset,
   output logic system_reset,
   output logic power_down_flag,
   output logic watchdog_timeout_flag,
   output logic osc_out_pin_o,
   output logic osc_out_pin_oe_n
);
   hwcc_state_all_type r;
   hwcc_state_all_type n;
   logic rst_sync;
   logic rst_req;
   logic bus_wr;
   logic bus_rd;
   logic [7:0] port_fall;
   logic [3:0] irq_new;

   function automatic logic addr_is(input logic [31:0] a, input logic [11:0] off);
      addr_is = (a[11:0] == off) && (a[31:12] == 20'h00000);
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync <= 1'b0;
         rst_req <= 1'b0;
      end else begin
         rst_sync <= ~external_reset_pin_n;
         rst_req <= rst_sync;
      end
   end

   always_comb begin
      bus_wr = psel && penable && pwrite;
      bus_rd = psel && !penable && !pwrite;
      port_fall = r.port_prev & ~port_a_in & r.wake_enable;
      irq_new = irq_flag & ~r.irq_masked;
      n = r;
      n.pready = psel && !penable;
      n.wdt_clear = 1'b0;
      n.wdt_reset = 1'b0;
      n.resume_next = 1'b0;
      n.irq_service = 1'b0;
      n.port_prev = port_a_in;
      if (bus_wr && addr_is(paddr, `HWCC_ADDR_CONFIG) && r.state == hwcc_run) begin
         n.rc_mode = pwdata[`HWCC_CFG_RC];
         n.wdt_from_osc = pwdata[`HWCC_CFG_WDTOSC];
         n.wake_enable = pwdata[`HWCC_CFG_WAKE_LSB +: `HWCC_PORT_W];
      end
      if (bus_rd) begin
         n.prdata = 32'h00000000;
         if (addr_is(paddr, `HWCC_ADDR_STATUS)) begin
            n.prdata[`HWCC_ST_PDF] = r.power_down_flag;
            n.prdata[`HWCC_ST_TO] = r.watchdog_timeout_flag;
            n.prdata[`HWCC_ST_HALTED] = (r.state == hwcc_halted);
            n.prdata[`HWCC_ST_DELAY] = (r.state == hwcc_restart);
         end else if (addr_is(paddr, `HWCC_ADDR_CONFIG)) begin
            n.prdata[`HWCC_CFG_RC] = r.rc_mode;
            n.prdata[`HWCC_CFG_WDTOSC] = r.wdt_from_osc;
            n.prdata[`HWCC_CFG_WAKE_LSB +: `HWCC_PORT_W] = r.wake_enable;
         end
      end
      // Halt and clear-watchdog also accept a bus write so software can drive them.
      if ((clear_watchdog_instr || (bus_wr && addr_is(paddr, `HWCC_ADDR_CTRL)
            && pwdata[`HWCC_CTRL_CLRWDT])) && r.state == hwcc_run) begin
         n.power_down_flag = 1'b0;
         n.wdt_clear = 1'b1;
      end
      case (r.state)
         hwcc_run: begin
            if (halt_instr || (bus_wr && addr_is(paddr, `HWCC_ADDR_CTRL)
                  && pwdata[`HWCC_CTRL_HALT])) begin
               n.state = hwcc_halted;
               n.osc_run = 1'b0;
               n.core_stall = 1'b1;
               n.wdt_clear = 1'b1;
               n.wdt_run = r.wdt_from_osc;
               n.power_down_flag = 1'b1;
               n.watchdog_timeout_flag = 1'b0;
               n.irq_masked = irq_flag;
            end
         end
         hwcc_halted: begin
            // The cause is latched in priority order so a single restart serves all events.
            if (r.wdt_run && wdt_overflow) begin
               n.cause = hwcc_cause_wdt;
               n.watchdog_timeout_flag = 1'b1;
            end else if (|irq_new) begin
               n.cause = hwcc_cause_irq;
            end else if (|port_fall) begin
               n.cause = hwcc_cause_port;
            end
            if (r.wdt_run && wdt_overflow || |irq_new || |port_fall) begin
               n.state = hwcc_restart;
               n.osc_run = 1'b1;
               n.count = '0;
            end
         end
         hwcc_restart: begin
            n.count = r.count + 11'h001;
            if (r.count == 11'(`HWCC_RESTART_CYCLES - 1)) begin
               n.state = hwcc_run;
               n.core_stall = 1'b0;
               n.wdt_run = 1'b1;
               n.irq_masked = '0;
               n.cause = hwcc_cause_none;
               if (r.cause == hwcc_cause_wdt) begin
                  n.wdt_reset = 1'b1;
               end else if (r.cause == hwcc_cause_irq &&
                     |(irq_new & irq_enable) && !stack_full) begin
                  n.irq_service = 1'b1;
               end else begin
                  n.resume_next = 1'b1;
               end
            end
         end
         default: begin
            n.state = hwcc_run;
         end
      endcase
      if (r.rc_mode && r.osc_run) begin
         n.div = r.div + 2'h1;
      end
      n.osc_out_pin_oe_n = !(r.rc_mode && r.div < `HWCC_DIV_HALF);
      if (rst_req) begin
         n.state = hwcc_run;
         n.osc_run = 1'b1;
         n.core_stall = 1'b0;
         n.wdt_clear = 1'b1;
         n.wdt_run = 1'b1;
         n.cause = hwcc_cause_none;
         n.irq_masked = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.osc_run <= 1'b1;
         r.wdt_run <= 1'b1;
         r.osc_out_pin_oe_n <= 1'b1;
         r.port_prev <= 8'hff;
      end else begin
         r <= n;
      end
   end

   // The system reset pulse is registered separately from the core state struct.
   logic sys_rst_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_rst_q <= 1'b1;
      end else begin
         sys_rst_q <= rst_req;
      end
   end

   always_comb begin
      prdata = r.prdata;
      pready = r.pready;
      pslverr = 1'b0;
      osc_run = r.osc_run;
      core_stall = r.core_stall;
      resume_next = r.resume_next;
      irq_service = r.irq_service;
      wdt_clear = r.wdt_clear;
      wdt_run = r.wdt_run;
      wdt_reset = r.wdt_reset;
      system_reset = sys_rst_q;
      power_down_flag = r.power_down_flag;
      watchdog_timeout_flag = r.watchdog_timeout_flag;
      osc_out_pin_o = 1'b0;
      osc_out_pin_oe_n = r.osc_out_pin_oe_n;
   end
endmodule

// *** bench/hwcc_core_model.sv ***
// Processor core stand-in that issues halt and clear-watchdog strobes.
`timescale 1ns/1ps
module hwcc_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt_req,
   input wire logic clr_req,
   input wire logic core_stall,
   output logic halt_instr,
   output logic clear_watchdog_instr
);
   // A held core executes nothing, so no strobe may leave it while stalled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_instr <= 1'b0;
         clear_watchdog_instr <= 1'b0;
      end else begin
         halt_instr <= halt_req && !core_stall;
         clear_watchdog_instr <= clr_req && !core_stall;
      end
   end
endmodule

// *** bench/hwcc_monitor.sv ***
// Checker for halt entry, wake-up and clock output behaviour.
`timescale 1ns/1ps
module hwcc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt_instr,
   input wire logic clear_watchdog_instr,
   input wire logic external_reset_pin_n,
   input wire logic osc_run,
   input wire logic core_stall,
   input wire logic resume_next,
   input wire logic irq_service,
   input wire logic wdt_reset,
   input wire logic wdt_clear,
   input wire logic system_reset,
   input wire logic power_down_flag,
   input wire logic watchdog_timeout_flag,
   input wire logic osc_out_pin_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [10:0] cnt;
   logic go;
   // The restart span is too long for a repetition, so it is counted here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 11'h000;
      end else begin
         cnt <= (osc_run && core_stall) ? cnt + 11'h001 : 11'h000;
      end
   end
   assign go = halt_instr && osc_run && !core_stall && !clear_watchdog_instr && !system_reset;
   a_halt_entry: assert property (go |=> !osc_run && core_stall && power_down_flag
      && !watchdog_timeout_flag && wdt_clear) else $error("halt entry wrong");
   a_halt_only: assert property ($fell(osc_run) |-> $past(halt_instr))
      else $error("halt without instruction");
   a_clrwdt_pdf: assert property (clear_watchdog_instr && osc_run && !core_stall
      && !halt_instr |=> !power_down_flag) else $error("power-down flag kept");
   a_restart_len: assert property ((resume_next || irq_service || wdt_reset)
      |-> cnt == 11'h400 && !core_stall) else $error("restart length wrong");
   a_one_outcome: assert property ($onehot0({resume_next, irq_service, wdt_reset}))
      else $error("two outcomes at once");
   a_halt_frozen: assert property (!osc_run |-> core_stall && !resume_next
      && !irq_service) else $error("core moved while halted");
   a_clk_quarter: assert property ($rose(osc_out_pin_oe_n) && osc_run && !halt_instr
      |=> osc_out_pin_oe_n ##1 !osc_out_pin_oe_n) else $error("clock out not quarter");
   a_ext_reset: assert property ($fell(external_reset_pin_n)
      ##1 !external_reset_pin_n [*3] |-> system_reset) else $error("pin reset not seen");
   a_wdt_flag: assert property (wdt_reset |-> watchdog_timeout_flag)
      else $error("time-out flag not set");
   c_resume: cover property (resume_next);
   c_service: cover property (irq_service);
   c_wdt: cover property (wdt_reset);
endmodule
bind hwcc_top hwcc_monitor i_mon (.pclk, .presetn, .halt_instr, .clear_watchdog_instr,
   .external_reset_pin_n, .osc_run, .core_stall, .resume_next, .irq_service, .wdt_reset,
   .wdt_clear, .system_reset, .power_down_flag, .watchdog_timeout_flag, .osc_out_pin_oe_n);

// *** bench/tb.sv ***
// Self-checking bench for the halt, wake-up and clock control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_req, clr_req;
   logic halt_instr, clear_watchdog_instr, external_reset_pin_n, stack_full, wdt_overflow;
   logic osc_run, core_stall, resume_next, irq_service, wdt_clear, wdt_run, wdt_reset;
   logic system_reset, power_down_flag, watchdog_timeout_flag, osc_out_pin_o, osc_out_pin_oe_n;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [7:0] port_a_in;
   logic [3:0] irq_flag, irq_enable;
   int n_mismatch = 0;
   int n_tests = 0;
   hwcc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .halt_instr, .clear_watchdog_instr, .external_reset_pin_n,
      .port_a_in, .irq_flag, .irq_enable, .stack_full, .wdt_overflow, .osc_run, .core_stall,
      .resume_next, .irq_service, .wdt_clear, .wdt_run, .wdt_reset, .system_reset,
      .power_down_flag, .watchdog_timeout_flag, .osc_out_pin_o, .osc_out_pin_oe_n);
   hwcc_core_model i_core (.pclk, .presetn, .halt_req, .clr_req, .core_stall, .halt_instr,
      .clear_watchdog_instr);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int i;
      logic got;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      got = 1'b0;
      // Outputs are read at the falling edge, where they already hold their value for the next rise.
      while (got !== 1'b1 && i < 20) begin
         @(negedge pclk);
         got = pready;
         rd = prdata;
         @(posedge pclk);
         i++;
      end
      {psel, penable} <= 2'h0;
      if (got !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
   endtask
   task halt;
      @(posedge pclk);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("osc_run", 1'b0, osc_run)
   endtask
   task wait_out(input logic [2:0] e, input int n_cyc);
      int i;
      logic [2:0] seen;
      i = 0;
      seen = 3'h0;
      while (seen === 3'h0 && i < 1200) begin
         @(negedge pclk);
         seen = {wdt_reset, irq_service, resume_next};
         i++;
      end
      `CHK("outcome", e, seen)
      `CHK("restart", n_cyc, i)
      if (i >= 1200) begin
         test_done();
      end
      @(posedge pclk);
   endtask
   task t_port;
      halt();
      port_a_in <= 8'hfe;
      repeat (20) @(posedge pclk);
      `CHK("osc_run", 1'b0, osc_run)
      apb(1'b0, 32'h4, 32'h0);
      `CHK("status", 4'h5, rd[3:0])
      `CHK("wdt_run", 1'b1, wdt_run)
      port_a_in <= 8'hf6;
      wait_out(3'h1, 1026);
      port_a_in <= 8'hff;
   endtask
   task t_wdt_stopped;
      apb(1'b1, 32'h8, 32'h0801);
      halt();
      `CHK("wdt_run", 1'b0, wdt_run)
      wdt_overflow <= 1'b1;
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      repeat (20) @(posedge pclk);
      `CHK("osc_run", 1'b0, osc_run)
      port_a_in <= 8'hf6;
      wait_out(3'h1, 1026);
      port_a_in <= 8'hff;
      apb(1'b1, 32'h8, 32'h0803);
   endtask
   task t_config;
      int k;
      logic [3:0] highs;
      apb(1'b0, 32'h8, 32'h0);
      `CHK("config", 32'h0, rd)
      `CHK("clk_out_oe", 1'b1, osc_out_pin_oe_n)
      apb(1'b1, 32'h8, 32'h0803);
      apb(1'b0, 32'h8, 32'h0);
      `CHK("config", 32'h0803, rd)
      apb(1'b0, 32'hc, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      highs = 4'h0;
      for (k = 0; k < 8; k++) begin
         @(negedge pclk);
         highs = highs + {3'h0, osc_out_pin_oe_n};
         `CHK("clk_out", 1'b0, osc_out_pin_o)
      end
      @(posedge pclk);
      `CHK("clk_out_high", 4'h4, highs)
   endtask
   task t_reset;
      halt();
      external_reset_pin_n <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK("reset", 2'h3, {system_reset, osc_run})
      `CHK("pdf", 1'b1, power_down_flag)
      external_reset_pin_n <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK("reset", 2'h1, {system_reset, osc_run})
      apb(1'b1, 32'h0, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("pdf", 1'b0, power_down_flag)
   endtask
   task t_irq(input logic [3:0] en, input logic sf, input logic [2:0] e);
      {irq_flag, irq_enable, stack_full} <= {4'h2, en, sf};
      halt();
      repeat (20) @(posedge pclk);
      `CHK("osc_run", 1'b0, osc_run)
      irq_flag <= 4'h6;
      wait_out(e, 1026);
      irq_flag <= 4'h0;
      @(posedge pclk);
   endtask
   task t_wdt;
      halt();
      wdt_overflow <= 1'b1;
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      wait_out(3'h4, 1025);
      apb(1'b0, 32'h4, 32'h0);
      `CHK("flags", 2'h3, rd[1:0])
      clr_req <= 1'b1;
      @(posedge pclk);
      clr_req <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("pdf", 1'b0, power_down_flag)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, halt_req, clr_req, stack_full, wdt_overflow} = 8'h00;
      {paddr, pwdata, irq_flag, irq_enable, external_reset_pin_n} = {64'h0, 9'h001};
      port_a_in = 8'hff;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_config();
      t_port();
      t_wdt_stopped();
      t_irq(4'h4, 1'b0, 3'h2);
      t_irq(4'h4, 1'b1, 3'h1);
      t_irq(4'h0, 1'b0, 3'h1);
      t_wdt();
      t_reset();
      test_done();
   end
endmodule
